/* File: bcpd_ctrl.v */
`timescale 1ns/1ps
`default_nettype none
`include "bcpd_defines.vh"
module bcpd_ctrl #(
   parameter TICK_CYC = `BCPD_TICK_CYC
) (
   input  wire        clk_i,
   input  wire        rst_i,
   input  wire        cyc_i,
   input  wire        stb_i,
   input  wire        we_i,
   input  wire [11:0] adr_i,
   input  wire [3:0]  sel_i,
   input  wire [31:0] dat_i,
   output reg  [31:0] dat_o,
   output reg         ack_o,
   input  wire [5:0]  enable_control_inputs_i,
   input  wire [2:0]  conv_pin_en_i,
   input  wire [2:0]  rails_ok_one_i,
   input  wire [2:0]  rails_ok_two_i,
   input  wire [2:0]  rails_ok_four_i,
   input  wire        host_lvl_one_i,
   input  wire        host_lvl_two_i,
   input  wire        host_lvl_four_i,
   output wire [2:0]  conv_en_o,
   output wire [2:0]  conv_fpwm_o,
   output wire        general_output_one_o,
   output wire        general_output_two_o,
   output wire        general_output_four_o
);
// ==========================================
// registers
reg  [5:0] conv_r;
reg  [7:0] delay_r;
reg  [5:0] outsel_r;
wire       hit;
wire [9:0] idx;
assign idx = adr_i[11:2];
assign hit = cyc_i & stb_i & ~ack_o;
// unused group inputs tie high so a pin may group fewer rails
wire [2:0]  en_sync;
wire [8:0]  ok_sync;
wire [2:0]  lv_sync;
wire [2:0]  good;
wire [2:0]  cnt_busy;
// ==========================================
// pin synchronisers; pins are asynchronous to the bus clock
bcpd_sync #(
   .WIDTH (3)
) i_sync_en (
   .clk_i (clk_i),
   .d_i   (conv_pin_en_i),
   .q_o   (en_sync)
);
bcpd_sync #(
   .WIDTH (9)
) i_sync_ok (
   .clk_i (clk_i),
   .d_i   ({rails_ok_four_i, rails_ok_two_i, rails_ok_one_i}),
   .q_o   (ok_sync)
);
bcpd_sync #(
   .WIDTH (3)
) i_sync_lvl (
   .clk_i (clk_i),
   .d_i   ({host_lvl_four_i, host_lvl_two_i, host_lvl_one_i}),
   .q_o   (lv_sync)
);
// ==========================================
// address decode
wire        sel_conv;
wire        sel_delay;
wire        sel_outsel;
wire        sel_status;
wire        wr_en;
wire        rd_en;
reg  [31:0] rd_nxt;
assign sel_conv   = (idx == {2'h0, `BCPD_IDX_CONV});
assign sel_delay  = (idx == {2'h0, `BCPD_IDX_DELAY});
assign sel_outsel = (idx == {2'h0, `BCPD_IDX_OUTSEL});
assign sel_status = (idx == {2'h0, `BCPD_IDX_STATUS});
assign wr_en      = hit & we_i & sel_i[0];
assign rd_en      = hit & ~we_i;
// ==========================================
// read select; unmapped words read as zero but are still acked
always @* begin
   rd_nxt = 32'h0000_0000;
   if (sel_conv) begin
      rd_nxt = {{26{1'b0}}, conv_r};
   end else if (sel_delay) begin
      rd_nxt = {{24{1'b0}}, delay_r};
   end else if (sel_outsel) begin
      rd_nxt = {{26{1'b0}}, outsel_r};
   end else if (sel_status) begin
      rd_nxt = {{26{1'b0}}, cnt_busy, good};
   end
end
// ==========================================
// wishbone slave; ack one cycle after the strobe, never two in a row
always @(posedge clk_i) begin
   if (rst_i) begin
      ack_o    <= 1'b0;
      dat_o    <= 32'h0000_0000;
      conv_r   <= `BCPD_CONV_RST;
      delay_r  <= `BCPD_DELAY_RST;
      outsel_r <= `BCPD_OUTSEL_RST;
   end else begin
      ack_o <= hit;
      if (wr_en && sel_conv) begin
         conv_r <= dat_i[`BCPD_CONV_MSB:0];
      end
      if (wr_en && sel_delay) begin
         delay_r <= dat_i[`BCPD_DELAY_MSB:0];
      end
      if (wr_en && sel_outsel) begin
         outsel_r <= dat_i[`BCPD_OUTSEL_MSB:0];
      end
      if (rd_en) begin
         dat_o <= rd_nxt;
      end
   end
end
// ==========================================
// converter control
assign conv_fpwm_o[2] = conv_r[`BCPD_MODE3_BIT];
assign conv_fpwm_o[1] = conv_r[`BCPD_MODE2_BIT];
assign conv_fpwm_o[0] = conv_r[`BCPD_MODE1_BIT];
assign conv_en_o[2]   = conv_r[`BCPD_KILL3_BIT] & en_sync[2];
assign conv_en_o[1]   = conv_r[`BCPD_KILL2_BIT] & en_sync[1];
assign conv_en_o[0]   = conv_r[`BCPD_KILL1_BIT] & en_sync[0];
// ==========================================
// delay decode in ms; the first pin's field is two bits wide
wire [6:0]  tgt_one;
wire [6:0]  tgt_two;
wire [6:0]  tgt_four;
bcpd_ms_decode i_dec_one (
   .code_i ({1'b0, delay_r[`BCPD_DLY1_HI:`BCPD_DLY1_LO]}),
   .ms_o   (tgt_one)
);
bcpd_ms_decode i_dec_two (
   .code_i (delay_r[`BCPD_DLY2_HI:`BCPD_DLY2_LO]),
   .ms_o   (tgt_two)
);
bcpd_ms_decode i_dec_four (
   .code_i (delay_r[`BCPD_DLY4_HI:`BCPD_DLY4_LO]),
   .ms_o   (tgt_four)
);
// ==========================================
// per-pin timers; exact nominal, well inside tolerance
bcpd_pin_timer #(
   .TICK_CYC (TICK_CYC)
) i_timer_one (
   .clk_i       (clk_i),
   .rst_i       (rst_i),
   .rails_ok_i  (ok_sync[2:0]),
   .target_ms_i (tgt_one),
   .good_o      (good[0]),
   .busy_o      (cnt_busy[0])
);
bcpd_pin_timer #(
   .TICK_CYC (TICK_CYC)
) i_timer_two (
   .clk_i       (clk_i),
   .rst_i       (rst_i),
   .rails_ok_i  (ok_sync[5:3]),
   .target_ms_i (tgt_two),
   .good_o      (good[1]),
   .busy_o      (cnt_busy[1])
);
bcpd_pin_timer #(
   .TICK_CYC (TICK_CYC)
) i_timer_four (
   .clk_i       (clk_i),
   .rst_i       (rst_i),
   .rails_ok_i  (ok_sync[8:6]),
   .target_ms_i (tgt_four),
   .good_o      (good[2]),
   .busy_o      (cnt_busy[2])
);
// ==========================================
// pin use select; host use bypasses the timer entirely
bcpd_pin_mux i_mux_one (
   .clk_i      (clk_i),
   .rst_i      (rst_i),
   .use_i      (outsel_r[`BCPD_USE1_HI:`BCPD_USE1_LO]),
   .good_i     (good[0]),
   .host_lvl_i (lv_sync[0]),
   .pin_o      (general_output_one_o)
);
bcpd_pin_mux i_mux_two (
   .clk_i      (clk_i),
   .rst_i      (rst_i),
   .use_i      (outsel_r[`BCPD_USE2_HI:`BCPD_USE2_LO]),
   .good_i     (good[1]),
   .host_lvl_i (lv_sync[1]),
   .pin_o      (general_output_two_o)
);
bcpd_pin_mux i_mux_four (
   .clk_i      (clk_i),
   .rst_i      (rst_i),
   .use_i      (outsel_r[`BCPD_USE4_HI:`BCPD_USE4_LO]),
   .good_i     (good[2]),
   .host_lvl_i (lv_sync[2]),
   .pin_o      (general_output_four_o)
);
endmodule // bcpd_ctrl

// ==========================================
// two-flop synchroniser; only the second stage leaves the module
module bcpd_sync #(
   parameter WIDTH = 1
) (
   input  wire             clk_i,
   input  wire [WIDTH-1:0] d_i,
   output wire [WIDTH-1:0] q_o
);
reg  [WIDTH-1:0] meta_r;
reg  [WIDTH-1:0] sync_r;
always @(posedge clk_i) begin
   meta_r <= d_i;
   sync_r <= meta_r;
end
assign q_o = sync_r;
endmodule // bcpd_sync

// ==========================================
// delay code to nominal milliseconds
module bcpd_ms_decode (
   input  wire [2:0] code_i,
   output reg  [6:0] ms_o
);
always @* begin
   case (code_i)
      3'h0:    ms_o = `BCPD_MS_C0;
      3'h1:    ms_o = `BCPD_MS_C1;
      3'h2:    ms_o = `BCPD_MS_C2;
      3'h3:    ms_o = `BCPD_MS_C3;
      3'h4:    ms_o = `BCPD_MS_C4;
      3'h5:    ms_o = `BCPD_MS_C5;
      3'h6:    ms_o = `BCPD_MS_C6;
      default: ms_o = `BCPD_MS_C7;
   endcase
end
endmodule // bcpd_ms_decode

// ==========================================
// power-good delay timer for one output pin
module bcpd_pin_timer #(
   parameter TICK_CYC = `BCPD_TICK_CYC,
   parameter TICK_W   = 32,
   parameter MS_W     = 7,
   parameter GROUP    = 3
) (
   input  wire              clk_i,
   input  wire              rst_i,
   input  wire [GROUP-1:0]  rails_ok_i,
   input  wire [MS_W-1:0]   target_ms_i,
   output wire              good_o,
   output wire              busy_o
);
// ==========================================
// grouping
// every grouped rail must regulate; one drop restarts the wait
wire              all_ok;
assign all_ok = &rails_ok_i;
// ==========================================
// millisecond prescaler and counter
localparam [TICK_W-1:0] TICK_LAST = TICK_CYC - 1;
localparam [TICK_W-1:0] ONE_TICK  = 1;
localparam [MS_W-1:0]   ONE_MS    = 1;
reg  [TICK_W-1:0] tick_r;
reg  [TICK_W-1:0] tick_nxt;
reg  [MS_W-1:0]   ms_r;
reg  [MS_W-1:0]   ms_nxt;
reg               good_r;
reg               good_nxt;
wire              tick_end;
wire              wait_done;
assign tick_end  = (tick_r == TICK_LAST);
assign wait_done = (ms_r >= target_ms_i);
// ==========================================
// next state
// a target rewritten mid-wait takes effect at once; a new target at or
// below the count ends the wait and the count holds where it stands
always @* begin
   tick_nxt = tick_r;
   ms_nxt   = ms_r;
   good_nxt = good_r;
   if (!all_ok) begin
      tick_nxt = {TICK_W{1'b0}};
      ms_nxt   = {MS_W{1'b0}};
      good_nxt = 1'b0;
   end else if (wait_done) begin
      good_nxt = 1'b1;
   end else if (tick_end) begin
      tick_nxt = {TICK_W{1'b0}};
      ms_nxt   = ms_r + ONE_MS;
   end else begin
      tick_nxt = tick_r + ONE_TICK;
   end
end
// ==========================================
// state
always @(posedge clk_i) begin
   if (rst_i) begin
      tick_r <= {TICK_W{1'b0}};
      ms_r   <= {MS_W{1'b0}};
      good_r <= 1'b0;
   end else begin
      tick_r <= tick_nxt;
      ms_r   <= ms_nxt;
      good_r <= good_nxt;
   end
end
// busy while every rail regulates and the wait has not ended
assign good_o = good_r;
assign busy_o = all_ok & ~good_r;
endmodule // bcpd_pin_timer

// ==========================================
// output pin use select
module bcpd_pin_mux (
   input  wire       clk_i,
   input  wire       rst_i,
   input  wire [1:0] use_i,
   input  wire       good_i,
   input  wire       host_lvl_i,
   output wire       pin_o
);
reg  pin_r;
reg  pin_nxt;
// shifter and spare codes follow power good; no level path is modelled
always @* begin
   case (use_i)
      `BCPD_USE_HOST: pin_nxt = host_lvl_i;
      default:        pin_nxt = good_i;
   endcase
end
always @(posedge clk_i) begin
   if (rst_i) begin
      pin_r <= 1'b0;
   end else begin
      pin_r <= pin_nxt;
   end
end
assign pin_o = pin_r;
endmodule // bcpd_pin_mux

`default_nettype wire

/* File: bcpd_defines.vh */
`ifndef BCPD_DEFINES_VH
`define BCPD_DEFINES_VH
// ==========================================
// register map (word index, byte addr = 4 * index)
`define BCPD_IDX_CONV       8'h9C
`define BCPD_IDX_DELAY      8'h9D
`define BCPD_IDX_OUTSEL     8'hC0
`define BCPD_IDX_STATUS     8'hC1
// ==========================================
// reset values
`define BCPD_CONV_RST       6'h3F
`define BCPD_DELAY_RST      8'h00
`define BCPD_OUTSEL_RST     6'h00
// ==========================================
// output pin uses
`define BCPD_USE_GOOD       2'h0
`define BCPD_USE_SHIFT      2'h1
`define BCPD_USE_HOST       2'h2
// ==========================================
// field positions
`define BCPD_MODE3_BIT      5
`define BCPD_MODE2_BIT      4
`define BCPD_MODE1_BIT      3
`define BCPD_KILL3_BIT      2
`define BCPD_KILL2_BIT      1
`define BCPD_KILL1_BIT      0
`define BCPD_CONV_MSB       5
`define BCPD_DELAY_MSB      7
`define BCPD_OUTSEL_MSB     5
`define BCPD_DLY2_HI        7
`define BCPD_DLY2_LO        5
`define BCPD_DLY4_HI        4
`define BCPD_DLY4_LO        2
`define BCPD_DLY1_HI        1
`define BCPD_DLY1_LO        0
`define BCPD_USE1_HI        1
`define BCPD_USE1_LO        0
`define BCPD_USE2_HI        3
`define BCPD_USE2_LO        2
`define BCPD_USE4_HI        5
`define BCPD_USE4_LO        4
// ==========================================
// nominal delay per code, ms
`define BCPD_MS_C0          7'h00
`define BCPD_MS_C1          7'h05
`define BCPD_MS_C2          7'h0A
`define BCPD_MS_C3          7'h0F
`define BCPD_MS_C4          7'h14
`define BCPD_MS_C5          7'h32
`define BCPD_MS_C6          7'h4B
`define BCPD_MS_C7          7'h64
// ==========================================
// timing
`define BCPD_MS_NS          1000000
`define BCPD_CLK_NS         4
`define BCPD_TICK_CYC       (`BCPD_MS_NS / `BCPD_CLK_NS)
`endif

/* File: bcpd_host.sv */
`timescale 1ns/1ps
`default_nettype none
// ====
// host bus master
module bcpd_host (
   input  wire logic        clk_i, ack_i,
   output var  logic        cyc_o, stb_o, we_o,
   output var  logic [11:0] adr_o,
   output var  logic [31:0] dat_o
);
   logic to = 0;
   initial {cyc_o, stb_o, we_o, adr_o, dat_o} = '0;
   task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n = 0;
      @(posedge clk_i);
      {cyc_o, stb_o, we_o, adr_o, dat_o} <= {2'b11, w, a, d};
      do @(posedge clk_i); while (ack_i !== 1'b1 && ++n < 40);
      to = n >= 40;
      {cyc_o, stb_o, dat_o} <= {2'b00, ~d}; // stale data would hide a late sample
   endtask
endmodule // bcpd_host
`default_nettype wire

/* File: bcpd_props.sv */
`timescale 1ns/1ps
`default_nettype none
// ====
// bus and output checks
module bcpd_props #(parameter TICK_CYC = 10) (
   input wire logic        clk_i, rst_i, cyc_i, stb_i, we_i, ack_o,
   input wire logic        general_output_one_o, general_output_two_o, general_output_four_o,
   input wire logic [2:0]  rails_ok_one_i, rails_ok_two_i, rails_ok_four_i, conv_en_o,
   input wire logic [2:0]  conv_fpwm_o,
   input wire logic [3:0]  sel_i,
   input wire logic [11:0] adr_i,
   input wire logic [31:0] dat_i, dat_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   wire cw = cyc_i && stb_i && we_i && ack_o && sel_i[0] && adr_i == 12'h270;
   a_ack_once: assert property (ack_o |=> !ack_o) else $error("ack long");
   a_ack_next: assert property (cyc_i && stb_i && !ack_o |=> ack_o) else $error("no ack");
   a_mode_bits: assert property (cw |=> conv_fpwm_o == $past(dat_i[5:3]))
      else $error("mode");
   a_kill_off: assert property (cw |=> !(conv_en_o & ~$past(dat_i[2:0])))
      else $error("kill");
   a_rsvd_zero: assert property (ack_o && !we_i && adr_i == 12'h270 |-> dat_o[7:6] == 0)
      else $error("rsvd");
   a_one_drop: assert property ($fell(&rails_ok_one_i) |-> ##[1:5] !general_output_one_o)
      else $error("one");
   a_two_drop: assert property ($fell(&rails_ok_two_i) |-> ##[1:5] !general_output_two_o)
      else $error("two");
   a_four_drop: assert property ($fell(&rails_ok_four_i) |-> ##[1:5] !general_output_four_o)
      else $error("four");
   cover property (cw);
   cover property ($rose(general_output_four_o));
   cover property (ack_o && !we_i);
endmodule // bcpd_props
bind bcpd_ctrl bcpd_props #(.TICK_CYC(TICK_CYC)) u_props (.*);
`default_nettype wire

/* File: buck_ctrl_pg_delay_regs_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
// ====
// bench
module buck_ctrl_pg_delay_regs_tb_top;
   logic        clk_i = 0, rst_i = 1, we_i, cyc_i, stb_i, ack_o;
   logic [11:0] adr_i;
   logic [31:0] dat_i, dat_o;
   logic [2:0]  conv_pin_en_i = 7, ok = 0, hl = 0, conv_en_o, conv_fpwm_o, out;
   int          fails = 0, n_tests = 0, e, w[3], t[8] = '{0, 5, 10, 15, 20, 50, 75, 100};
   bcpd_ctrl #(.TICK_CYC(10)) i_dut (.*, .sel_i(4'hF), .enable_control_inputs_i(6'h3F),
      .rails_ok_one_i({3{ok[0]}}), .rails_ok_two_i({3{ok[1]}}), .rails_ok_four_i({3{ok[2]}}),
      .host_lvl_one_i(hl[0]), .host_lvl_two_i(hl[1]), .host_lvl_four_i(hl[2]),
      .general_output_one_o(out[0]), .general_output_two_o(out[1]),
      .general_output_four_o(out[2]));
   bcpd_host i_host (.clk_i, .ack_i(ack_o), .cyc_o(cyc_i), .stb_o(stb_i), .we_o(we_i),
      .adr_o(adr_i), .dat_o(dat_i));
   initial forever #2 clk_i = ~clk_i;
   task automatic chk(string s, logic [31:0] lo, hi, v);
      n_tests++;
      if ((v >= lo && v <= hi) !== 1'b1) begin
         fails++;
         $display("mismatch %s expected %0d..%0d seen %0d", s, lo, hi, v);
      end
   endtask
   task automatic acc(logic wr, logic [11:0] a, logic [31:0] d);
      i_host.xfer(wr, a, d);
      if (i_host.to) results();
      if (!wr) chk("reg", d, d, dat_o);
   endtask
   task automatic results();
      fails += i_host.to;
      $display("tests %0d fails %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   initial begin
      repeat (5) @(posedge clk_i);
      rst_i <= 0;
      acc(0, 12'h274, 0);
      acc(1, 12'h270, 32'hFF);
      acc(0, 12'h270, 32'h3F);
      acc(0, 12'h3FC, 0);
      for (int i = 0; i < 8; i++) begin
         acc(1, 12'h270, {i[2:0], ~i[2:0]});
         repeat (4) @(posedge clk_i);
         chk("mode", i, i, conv_fpwm_o);
         chk("enable", 7 - i, 7 - i, conv_en_o);
      end
      $display("test ctrl done");
      for (int c = 0; c < 8; c++) begin
         acc(1, 12'h274, {c[2:0], c[2:0], c[1:0]});
         w = '{-1, -1, -1};
         ok <= 7;
         for (int k = 0; k < 1200; k++) begin
            @(posedge clk_i);
            foreach (w[p]) if (w[p] < 0 && out[p] === 1'b1) w[p] = k;
         end
         foreach (w[p]) begin
            e = t[p ? c : c & 3];
            chk("wait", e * 9, e * 11 + 6, w[p]);
         end
         ok <= 0;
         repeat (8) @(posedge clk_i);
      end
      $display("test delay done");
      acc(0, 12'h304, 0);
      acc(1, 12'h300, 32'h2A);
      acc(0, 12'h300, 32'h2A);
      for (int h = 7; h > 0; h -= 5) begin
         hl <= h[2:0];
         repeat (6) @(posedge clk_i);
         chk("host", h, h, out);
      end
      $display("test host done");
      acc(1, 12'h274, 0);
      acc(1, 12'h300, 32'h15);
      ok <= 7;
      repeat (8) @(posedge clk_i);
      chk("shift", 7, 7, out);
      acc(0, 12'h304, 32'h07);
      $display("test shift done");
      results();
   end
endmodule // buck_ctrl_pg_delay_regs_tb_top
`default_nettype wire
